//--- pkg/sdr_defs.vh
// Purpose: Shared constants of the converter control register bank
// Assumes: Serial register addresses are 16-bit words sent before the 16-bit data
// Notes: Included by its bare name
`ifndef SDR_DEFS_VH
`define SDR_DEFS_VH

`define SDR_ADDR_CONTROL 16'h0001
`define SDR_ADDR_SCALE 16'h0004
`define SDR_ADDR_THRESH 16'h0005

`define SDR_CTRL_RESET 16'h0000
`define SDR_SCALE_RESET 16'hA000
`define SDR_THRESH_RESET 16'hCCCC
`define SDR_SCALE_UNITY 16'h8000

`define SDR_BIT_RD_THRESH 14
`define SDR_BIT_RD_SCALE 13
`define SDR_BIT_RD_STATUS 11
`define SDR_BIT_SYNC 9
`define SDR_BIT_BYPASS 7
`define SDR_BIT_SLEEP 3
`define SDR_BIT_LOW_POWER_INDICATOR 2
`define SDR_BIT_REFOFF 1
`define SDR_BIT_AMPOFF 0

// Control bits that hold a value; the rest read back as zero
`define SDR_CTRL_KEEP 16'h008F

`define SDR_FRAME_BITS 6'h20
`define SDR_START_CYCLES 2'h2
`define SDR_FULL_RUN 3'h4

`endif

//--- logic/sdr_regs.v
// Purpose: Start-up sequencing, control, status, scale and threshold registers
// Assumes: Serial clock comes from outside and is sampled by CLK; filter datapath outside
// Notes: Writes are one 16-bit address plus one 16-bit data word per frame
//
// Behaviour
// R1: Host holds reset for at least one master clock cycle.
// R2: Host waits two master clock cycles after reset before proceeding.
// R3: Host holds the alignment pin low at least four master clock periods.
// R4: Host never pulses alignment during a register write.
// R5: Without multi-device alignment the host keeps the alignment pin high.
// R6: Defaults apply after start-up; settled flag set once filter settling elapses.
// R7: A write is address then 16-bit data; scale and threshold accessible after start-up.
// R8: Control register is 16 bits at address 0x0001, resetting to 0x0000.
// R9: Bits 14, 13, 11 replace next read with threshold, scale, status.
// R10: Bits 14 to 11 and bit 9 clear themselves after taking effect.
// R11: Host sets at most one read-select bit per control write.
// R12: The chosen read-select bit decides the next output frame contents.
// R13: Writing bit 9 starts internal filter alignment.
// R14: Bit 7 bypasses the reference buffer only while the buffer is off.
// R15: Bit 3 powers down without reset; writing 0 restores operation.
// R16: Host writes bit 2 as one while in low power mode.
// R17: Bit 1 switches off reference buffer, bit 0 the input amplifier.
// R18: Status: settled 10, low power 9, overload 8, refoff 4, ampoff 3, ratio 1:0.
// R19: Scale at 0x0004 resets to 0xA000; 0x8000 is unity gain.
// R20: Threshold at 0x0005, reset 0xCCCC, compared to first stage before scaling.
// R21: Overload set at once after more than four consecutive full-reference samples.
// R22: Frame input sampled on falling serial edges; first data bit on next falling edge.
// R23: Power-down keeps all register contents.
`timescale 1ns/100ps
`default_nettype none
`include "sdr_defs.vh"

module sdr_regs #(
  parameter SETTLE_CONV = 8,
  parameter [0:0] PART_ID_BIT = 1'b0
) (
  input wire CLK,
  input wire RST,
  input wire SYNC_N,
  input wire SERIAL_CLOCK,
  input wire FRAME_IN_STROBE_N,
  input wire SERIAL_IN,
  output reg SERIAL_OUT,
  output reg FRAME_OUT_STROBE_N,
  input wire [1:0] DECIMATION_RATIO,
  input wire [23:0] CONV_DATA,
  input wire CONV_VALID,
  input wire [15:0] FIRST_STAGE_MAG,
  input wire FIRST_STAGE_VALID,
  input wire MOD_SAMPLE_VALID,
  input wire MOD_AT_FULL,
  output wire [15:0] OUTPUT_SCALE,
  output wire [15:0] OVERLOAD_THRESHOLD,
  output wire SLEEP,
  output wire REF_BUF_OFF,
  output wire INPUT_INPUT_AMP_DISABLE,
  output wire REF_BYPASS,
  output reg FILTER_ALIGN,
  output wire SETTLED
);

  // Pin synchronisers, two stages each; PART_ID_BIT value is arbitrary
  reg [1:0] sck_s;
  reg [1:0] fsi_s;
  reg [1:0] sdi_s;
  reg [1:0] sync_s;
  reg [1:0] dec_s0;
  reg [1:0] dec_s1;
  reg sck_d;
  reg sync_d;
  wire sck_fall;
  wire sck_rise;
  wire sync_fall;

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_s <= 2'h0;
      fsi_s <= 2'h3;
      sdi_s <= 2'h0;
      sync_s <= 2'h3;
      dec_s0 <= 2'h0;
      dec_s1 <= 2'h0;
      sck_d <= 1'b0;
      sync_d <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], SERIAL_CLOCK};
      fsi_s <= {fsi_s[0], FRAME_IN_STROBE_N};
      sdi_s <= {sdi_s[0], SERIAL_IN};
      sync_s <= {sync_s[0], SYNC_N};
      dec_s0 <= DECIMATION_RATIO;
      dec_s1 <= dec_s0;
      sck_d <= sck_s[1];
      sync_d <= sync_s[1];
    end
  end

  assign sck_fall = sck_d & ~sck_s[1];
  assign sck_rise = ~sck_d & sck_s[1];
  assign sync_fall = sync_d & ~sync_s[1];

  // Start-up: registers locked for two cycles after reset release
  reg [1:0] start_cnt;
  wire started;
  assign started = (start_cnt == `SDR_START_CYCLES);

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      start_cnt <= 2'h0;
    end else if (!started) begin
      start_cnt <= start_cnt + 2'h1;
    end
  end

  // Serial write receiver
  reg in_write;
  reg armed;
  reg [5:0] wr_cnt;
  reg [31:0] wr_shift;
  reg wr_commit;
  wire [31:0] wr_word;
  assign wr_word = {wr_shift[30:0], sdi_s[1]};

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_write <= 1'b0;
      armed <= 1'b1;
      wr_cnt <= 6'h00;
      wr_shift <= 32'h00000000;
      wr_commit <= 1'b0;
    end else begin
      wr_commit <= 1'b0;
      if (fsi_s[1]) begin
        armed <= 1'b1;
      end
      if (sck_fall) begin
        // R22: frame check on falling edge
        if (!in_write && armed && !fsi_s[1]) begin
          in_write <= 1'b1;
          armed <= 1'b0;
          wr_cnt <= 6'h00;
        end else if (in_write) begin
          wr_shift <= wr_word;
          if (wr_cnt == `SDR_FRAME_BITS - 6'h01) begin
            in_write <= 1'b0;
            wr_commit <= 1'b1;
          end else begin
            wr_cnt <= wr_cnt + 6'h01;
          end
        end
      end
    end
  end

  // Registers
  reg [15:0] ctrl;
  reg [15:0] scale;
  reg [15:0] thresh;
  reg [1:0] rd_sel;
  reg overload;
  reg settled;
  reg [15:0] settle_cnt;
  reg [2:0] full_run;
  wire wr_ok;
  wire [15:0] wr_addr;
  wire [15:0] wr_data;
  wire ctrl_wr;
  wire sync_req;
  wire frame_start;
  wire [15:0] status;

  assign wr_ok = wr_commit & started;
  assign wr_addr = wr_shift[31:16];
  assign wr_data = wr_shift[15:0];
  assign ctrl_wr = wr_ok && (wr_addr == `SDR_ADDR_CONTROL);
  // R13: bit 9 or pin starts alignment
  assign sync_req = (ctrl_wr && wr_data[`SDR_BIT_SYNC]) || sync_fall;

  // R8: control register
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl <= `SDR_CTRL_RESET;
      scale <= `SDR_SCALE_RESET;
      thresh <= `SDR_THRESH_RESET;
    end else if (wr_ok) begin
      // R7: write after start-up
      case (wr_addr)
        `SDR_ADDR_CONTROL: begin
          // R10: select and sync bits not stored
          ctrl <= wr_data & `SDR_CTRL_KEEP;
        end
        `SDR_ADDR_SCALE: begin
          // R19: scale, unity is 0x8000
          scale <= wr_data;
        end
        `SDR_ADDR_THRESH: begin
          // R20: threshold register
          thresh <= wr_data;
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Read select, 0 conversion, 1 threshold, 2 scale, 3 status
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_sel <= 2'h0;
    end else if (ctrl_wr && (wr_data[`SDR_BIT_RD_THRESH] || wr_data[`SDR_BIT_RD_SCALE] ||
                             wr_data[`SDR_BIT_RD_STATUS])) begin
      // R9: pick replacement; highest bit wins
      if (wr_data[`SDR_BIT_RD_THRESH]) begin
        rd_sel <= 2'h1;
      end else if (wr_data[`SDR_BIT_RD_SCALE]) begin
        rd_sel <= 2'h2;
      end else begin
        rd_sel <= 2'h3;
      end
    end else if (frame_start) begin
      // R10: cleared once used
      rd_sel <= 2'h0;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      FILTER_ALIGN <= 1'b0;
    end else begin
      // R10: one-cycle alignment pulse
      FILTER_ALIGN <= sync_req;
    end
  end

  // R6: settled after SETTLE_CONV conversions since reset or alignment
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      settle_cnt <= 16'h0000;
      settled <= 1'b0;
    end else if (sync_req) begin
      settle_cnt <= 16'h0000;
      settled <= 1'b0;
    end else if (CONV_VALID && !settled) begin
      if (settle_cnt == SETTLE_CONV[15:0] - 16'h0001) begin
        settled <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 16'h0001;
      end
    end
  end

  // Overload flag follows each first-stage sample; a new trip wins over clearing
  wire run_trip;
  assign run_trip = MOD_SAMPLE_VALID && MOD_AT_FULL && (full_run == `SDR_FULL_RUN);

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      full_run <= 3'h0;
      overload <= 1'b0;
    end else begin
      if (MOD_SAMPLE_VALID) begin
        if (!MOD_AT_FULL) begin
          full_run <= 3'h0;
        end else if (full_run != `SDR_FULL_RUN) begin
          full_run <= full_run + 3'h1;
        end
      end
      // R21: fifth full sample trips at once
      if (run_trip) begin
        overload <= 1'b1;
      end else if (FIRST_STAGE_VALID) begin
        // R20: compare before scaling
        overload <= (FIRST_STAGE_MAG > thresh);
      end
    end
  end

  // R18: status word layout
  assign status = {PART_ID_BIT, 1'b1, 2'h0, 1'b1, settled, ctrl[`SDR_BIT_LOW_POWER_INDICATOR], overload,
                   1'b0, 1'b1, 1'b0, ctrl[`SDR_BIT_REFOFF], ctrl[`SDR_BIT_AMPOFF], 1'b0,
                   dec_s1};

  // Output framer; a write frame overrides any read in progress
  reg out_pend;
  reg out_active;
  reg [5:0] out_cnt;
  reg [31:0] out_shift;
  reg [31:0] conv_word;
  reg [31:0] sel_word;

  assign frame_start = out_pend && sck_rise && !out_active && !in_write && !SLEEP;

  always @* begin
    conv_word = {CONV_DATA, status[15:8]};
    // R12: selection decides frame contents
    case (rd_sel)
      2'h1: sel_word = {thresh, 16'h0000};
      2'h2: sel_word = {scale, 16'h0000};
      2'h3: sel_word = {status, 16'h0000};
      default: sel_word = out_shift;
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_pend <= 1'b0;
      out_active <= 1'b0;
      out_cnt <= 6'h00;
      out_shift <= 32'h00000000;
      SERIAL_OUT <= 1'b0;
      FRAME_OUT_STROBE_N <= 1'b1;
    end else if (in_write || SLEEP) begin
      out_active <= 1'b0;
      out_pend <= 1'b0;
      FRAME_OUT_STROBE_N <= 1'b1;
      SERIAL_OUT <= 1'b0;
    end else begin
      if (CONV_VALID) begin
        out_pend <= 1'b1;
        out_shift <= conv_word;
      end
      if (frame_start) begin
        // R9: replacement word loaded at frame start
        out_pend <= 1'b0;
        out_active <= 1'b1;
        out_cnt <= 6'h00;
        SERIAL_OUT <= sel_word[31];
        out_shift <= {sel_word[30:0], 1'b0};
        FRAME_OUT_STROBE_N <= 1'b0;
      end else if (out_active && sck_rise) begin
        if (out_cnt == `SDR_FRAME_BITS - 6'h01) begin
          out_active <= 1'b0;
          FRAME_OUT_STROBE_N <= 1'b1;
          SERIAL_OUT <= 1'b0;
        end else begin
          out_cnt <= out_cnt + 6'h01;
          SERIAL_OUT <= out_shift[31];
          out_shift <= {out_shift[30:0], 1'b0};
        end
      end
    end
  end

  // R23: sleep gates only outputs, registers kept
  // R15: sleep bit
  assign SLEEP = ctrl[`SDR_BIT_SLEEP];
  // R17: buffer and amplifier off
  assign REF_BUF_OFF = ctrl[`SDR_BIT_REFOFF];
  assign INPUT_INPUT_AMP_DISABLE = ctrl[`SDR_BIT_AMPOFF];
  // R14: bypass only with buffer off
  assign REF_BYPASS = ctrl[`SDR_BIT_BYPASS] & ctrl[`SDR_BIT_REFOFF];
  // R19: scale applied by datapath
  assign OUTPUT_SCALE = scale;
  assign OVERLOAD_THRESHOLD = thresh;
  assign SETTLED = settled;

endmodule
`default_nettype wire

//--- verif/sdr_regs_sva.sv
// Purpose: Port-level checks of the converter register bank
// Assumes: Serial clock far slower than CLK
// Notes: Bound into sdr_regs
`timescale 1ns/100ps
`default_nettype none
module sdr_regs_sva (
  input wire CLK,
  input wire RST,
  input wire SYNC_N,
  input wire SERIAL_CLOCK,
  input wire FRAME_OUT_STROBE_N,
  input wire CONV_VALID,
  input wire [15:0] OUTPUT_SCALE,
  input wire [15:0] OVERLOAD_THRESHOLD,
  input wire SLEEP,
  input wire REF_BUF_OFF,
  input wire REF_BYPASS,
  input wire FILTER_ALIGN,
  input wire SETTLED
);
  logic sck_d;
  logic [5:0] rises;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Raw serial rises inside a read frame
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_d <= 1'b0;
      rises <= 6'h00;
    end else begin
      sck_d <= SERIAL_CLOCK;
      if (FRAME_OUT_STROBE_N) rises <= 6'h00;
      else if (SERIAL_CLOCK && !sck_d) rises <= rises + 6'h01;
    end
  end
  chk_frame_bits: assert property ($rose(FRAME_OUT_STROBE_N) |-> rises == 6'h20)
    else $error("Read frame length wrong");
  chk_align_pulse: assert property (FILTER_ALIGN |=> !FILTER_ALIGN)
    else $error("Align pulse too long");
  chk_bypass_gate: assert property (REF_BYPASS |-> REF_BUF_OFF)
    else $error("Bypass with buffer on");
  chk_settle_drop: assert property ($rose(FILTER_ALIGN) |-> ##[0:2] !SETTLED)
    else $error("Settled kept over align");
  chk_settle_conv: assert property ($rose(SETTLED) |->
    $past(CONV_VALID) || $past(CONV_VALID, 2) || $past(CONV_VALID, 3))
    else $error("Settled rose without conversion");
  chk_sync_pin: assert property ($fell(SYNC_N) |-> ##[1:6] FILTER_ALIGN)
    else $error("Pin align not taken");
  chk_sleep_quiet: assert property ($fell(FRAME_OUT_STROBE_N) |-> !SLEEP)
    else $error("Frame while asleep");
  chk_sleep_keeps: assert property ($changed(SLEEP) |->
    $stable(OUTPUT_SCALE) && $stable(OVERLOAD_THRESHOLD))
    else $error("Sleep change moved registers");
  chk_reset_vals: assert property (disable iff (1'b0) RST |->
    OUTPUT_SCALE == 16'hA000 && OVERLOAD_THRESHOLD == 16'hCCCC && !SLEEP)
    else $error("Reset values wrong");
  cover property ($fell(FRAME_OUT_STROBE_N));
  cover property ($rose(FILTER_ALIGN));
  cover property ($rose(SETTLED));
endmodule
bind sdr_regs sdr_regs_sva sdr_regs_sva_i (.CLK(CLK), .RST(RST), .SYNC_N(SYNC_N),
  .SERIAL_CLOCK(SERIAL_CLOCK), .FRAME_OUT_STROBE_N(FRAME_OUT_STROBE_N),
  .CONV_VALID(CONV_VALID), .OUTPUT_SCALE(OUTPUT_SCALE),
  .OVERLOAD_THRESHOLD(OVERLOAD_THRESHOLD), .SLEEP(SLEEP), .REF_BUF_OFF(REF_BUF_OFF),
  .REF_BYPASS(REF_BYPASS), .FILTER_ALIGN(FILTER_ALIGN), .SETTLED(SETTLED));
`default_nettype wire

//--- verif/sdr_host.sv
// Purpose: Host model on the frame-synchronized serial port
// Assumes: Half serial period of four CLK cycles
// Notes: Serial clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module sdr_host (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic fso_n,
  output logic sck = 1'b0,
  output logic fsi_n = 1'b1,
  output logic serial_in
);
  logic bit_r = 1'b0;
  logic pat = 1'b0;
  always @(posedge clk) pat <= ~pat;
  assign serial_in = fsi_n ? pat : bit_r;
  task automatic half(input logic lvl);
    @(posedge clk);
    sck <= lvl;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] w);
    fsi_n <= 1'b0;
    for (int k = 0; k < 33; k++) begin
      if (k > 0) bit_r <= w[32 - k];
      half(1'b1);
      half(1'b0);
    end
    fsi_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Bits sampled late in each period
  task automatic rd(output logic [31:0] r);
    r = 32'h0;
    for (int k = 0; k < 33; k++) begin
      half(1'b1);
      half(1'b0);
      if (!fso_n) r = {r[30:0], serial_out};
    end
  endtask
endmodule
`default_nettype wire

//--- verif/sdr_regs_tb.sv
// Purpose: Self-checking bench of the converter register bank
// Assumes: Host model runs the serial port at 400 ns
// Notes: Settling shortened to two conversions; part bit left at default
`timescale 1ns/100ps
`default_nettype none
`include "sdr_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module sdr_regs_tb;
  logic clk = 1'b0, rst = 1'b0, sync_n = 1'b1;
  logic cv = 1'b0, fv = 1'b0, mv = 1'b0, mf = 1'b0, m_ovl = 1'b0;
  logic [1:0] dec = 2'h0;
  logic [23:0] cd = 24'h0;
  logic [15:0] fm = 16'h0, lfsr = 16'hCEF4, m_ctrl = 16'h0;
  logic [15:0] m_scale = `SDR_SCALE_RESET, m_thr = `SDR_THRESH_RESET;
  logic [15:0] ctl [5] = '{16'h0080, 16'h0082, 16'h0008, 16'h0085, 16'h0007};
  int bsel [3] = '{14, 13, 11};
  int err_count = 0, n_compared = 0, cyc = 0, m_conv = 0, sel = 0, n_align = 0;
  wire sck, fsi_n, serial_in, serial_out, fso_n, sleep, refoff, ampoff, bypass, align, settled;
  wire [15:0] scale, thresh;
  sdr_regs #(.SETTLE_CONV(2)) sdr_regs_i (.CLK(clk), .RST(rst), .SYNC_N(sync_n),
    .SERIAL_CLOCK(sck), .FRAME_IN_STROBE_N(fsi_n), .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out),
    .FRAME_OUT_STROBE_N(fso_n), .DECIMATION_RATIO(dec), .CONV_DATA(cd), .CONV_VALID(cv),
    .FIRST_STAGE_MAG(fm), .FIRST_STAGE_VALID(fv), .MOD_SAMPLE_VALID(mv), .MOD_AT_FULL(mf),
    .OUTPUT_SCALE(scale), .OVERLOAD_THRESHOLD(thresh), .SLEEP(sleep), .REF_BUF_OFF(refoff),
    .INPUT_INPUT_AMP_DISABLE(ampoff), .REF_BYPASS(bypass), .FILTER_ALIGN(align), .SETTLED(settled));
  sdr_host sdr_host_i (.clk(clk), .serial_out(serial_out), .fso_n(fso_n), .sck(sck), .fsi_n(fsi_n),
    .serial_in(serial_in));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] stat();
    stat = {1'b0, 4'h9, m_conv >= 2, m_ctrl[2], m_ovl, 3'h2, m_ctrl[1:0], 1'b0, dec};
  endfunction
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    sdr_host_i.wr({a, d});
    if (a == `SDR_ADDR_SCALE) m_scale = d;
    if (a == `SDR_ADDR_THRESH) m_thr = d;
    if (a == `SDR_ADDR_CONTROL) begin
      m_ctrl = d & `SDR_CTRL_KEEP;
      sel = d[14] ? 1 : d[13] ? 2 : d[11] ? 3 : 0;
      if (d[9]) m_conv = 0;
    end
    `CHK("scale", m_scale, scale)
    `CHK("thresh", m_thr, thresh)
    `CHK("ctrl", m_ctrl[3:0] & 4'hB, {sleep, 1'b0, refoff, ampoff})
    `CHK("bypass", m_ctrl[7] & m_ctrl[1], bypass)
  endtask
  task automatic rd();
    logic [31:0] r, e;
    logic [15:0] s;
    logic [15:0] sc;
    lfsr = nxt(lfsr);
    @(posedge clk);
    cd <= {lfsr, lfsr[15:8]};
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    // Conversion frame carries the status as it stood before this conversion counted
    sc = stat();
    m_conv++;
    sdr_host_i.rd(r);
    s = stat();
    e = sel == 1 ? {m_thr, 16'h0} : sel == 2 ? {m_scale, 16'h0} : sel == 3 ? {s, 16'h0} :
      {cd, sc[15:8]};
    sel = 0;
    `CHK("frame", e, r)
  endtask
  task automatic smp(input logic md, input logic [15:0] m, input logic f, input logic o);
    @(posedge clk);
    mv <= md;
    mf <= f;
    fv <= !md;
    fm <= m;
    @(posedge clk);
    mv <= 1'b0;
    fv <= 1'b0;
    m_ovl = o;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (align) n_align++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    // Raised by non-blocking so the asynchronous reset sees a real edge
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    lfsr = nxt(lfsr);
    dec <= lfsr[1:0];
    repeat (4) @(posedge clk);
    wr(16'h0002, 16'hFFFF);
    wr(`SDR_ADDR_CONTROL, 16'h0800);
    rd();
    rd();
    `CHK("settled", 1'b1, settled)
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      wr(i % 3 == 0 ? `SDR_ADDR_SCALE : i % 3 == 1 ? `SDR_ADDR_THRESH : 16'h0003, lfsr);
    end
    foreach (ctl[i]) wr(`SDR_ADDR_CONTROL, ctl[i]);
    foreach (bsel[i]) begin
      wr(`SDR_ADDR_CONTROL, 16'h0007 | (16'h1 << bsel[i]));
      rd();
      rd();
    end
    wr(`SDR_ADDR_CONTROL, 16'h0207);
    `CHK("settled", 1'b0, settled)
    `CHK("align", 1, n_align)
    rd();
    rd();
    sync_n <= 1'b0;
    repeat (5) @(posedge clk);
    sync_n <= 1'b1;
    m_conv = 0;
    repeat (6) @(posedge clk);
    `CHK("settled", 1'b0, settled)
    `CHK("align", 2, n_align)
    wr(`SDR_ADDR_THRESH, 16'h7FFF);
    smp(1'b0, 16'h8000, 1'b0, 1'b1);
    wr(`SDR_ADDR_CONTROL, 16'h0807);
    rd();
    smp(1'b0, 16'h7FFF, 1'b0, 1'b0);
    for (int i = 0; i < 10; i++) smp(1'b1, 16'h0, i != 4, i > 8);
    wr(`SDR_ADDR_CONTROL, 16'h0807);
    rd();
    `CHK("align", 2, n_align)
    end_sim();
  end
endmodule
`default_nettype wire
